// ### design/pesc_counter.sv
// Event selector and counter for pipeline performance monitoring
`timescale 1ns/100ps

// Contract
// - CAH/20H counts cycles with no allocation while allocation stall is asserted.
// - CAH/3FH counts cycles the front end supplies nothing, any cause.
// - CAH/50H counts front end empty cycles while back end is not stalled.
// - Undelivered count excludes cycles where back end cannot accept micro-ops.
// - Allocation writes into one of six stations and stalls when target is full.
// - CBH/01H counts allocation stall cycles caused by full memory cluster station.
// - CBH/1FH counts allocation stall cycles caused by any full station.
// - Any-station stall counts only when a station is full, not other stalls.
// - CDH/01H counts cycles the divider is busy.
// - Divider busy counts regardless of waiting divides or empty station.
// - E6H counts resteers: 01H any, 08H return, 10H conditional branches.
// - E7H/01H counts each microcode sequencer flow start.
// - Second family: 02H/81H counts store-to-load data forwards.
// - Second family: 06H counts segment register loads.
// - Segment load count may include speculative loads never performed.
// - CAH/01H counts no-allocation cycles with fewer than two reorder entries free.
module pesc_counter
	import pesc_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Selection
	input wire pesc_sel_t sel_i,
	input wire logic family2_i,
	// Pipeline conditions
	input wire pesc_cond_t cond_i,
	// Result
	output logic [CNT_W-1:0] count_o,
	output logic supported_o,
	output logic hit_o
);

	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;
	logic hit;
	logic supported;
	logic no_alloc;
	logic reorder_full;
	logic any_full;

	// Derived pipeline conditions
	always_comb begin
		no_alloc = ~cond_i.uops_allocated;
		reorder_full = (cond_i.reorder_free < REORDER_FREE_W'(REORDER_FULL_LIMIT));
		// Station full stall only counts when a station is full and allocation stalls
		any_full = cond_i.alloc_stall & (|cond_i.station_full);
	end

	// Event decode
	always_comb begin
		hit = 1'b0;
		supported = 1'b1;
		if (family2_i) begin
			if (sel_i.code == EV_ST_FWD && sel_i.umask == UM_ST_FWD) begin
				hit = cond_i.st_fwd;
			end else if (sel_i.code == EV_SEG_LD) begin
				hit = cond_i.seg_load;
			end else begin
				supported = 1'b0;
			end
		end else begin
			case (sel_i.code)
				EV_NO_ALLOC: begin
					if (sel_i.umask == UM_REORDER_FULL) hit = no_alloc & reorder_full;
					else if (sel_i.umask == UM_ALLOC_STALL) hit = no_alloc & cond_i.alloc_stall;
					else if (sel_i.umask == UM_NO_ALLOC_ALL) hit = cond_i.frontend_empty;
					else if (sel_i.umask == UM_UNDELIVERED) hit = cond_i.frontend_empty & ~cond_i.backend_stalled;
					else supported = 1'b0;
				end
				EV_STATION_FULL: begin
					if (sel_i.umask == UM_MEMQ) begin
						hit = cond_i.alloc_stall & cond_i.station_full[MEMQ_IDX];
					end else if (sel_i.umask == UM_ANY_STATION) begin
						hit = any_full;
					end else begin
						supported = 1'b0;
					end
				end
				EV_DIV_BUSY: begin
					if (sel_i.umask == UM_DIV) hit = cond_i.div_busy;
					else supported = 1'b0;
				end
				EV_RESTEER: begin
					if (sel_i.umask == UM_RST_ANY) hit = cond_i.resteer;
					else if (sel_i.umask == UM_RST_RET) hit = cond_i.resteer_ret;
					else if (sel_i.umask == UM_RST_COND) hit = cond_i.resteer_cond;
					else supported = 1'b0;
				end
				EV_UCODE: begin
					if (sel_i.umask == UM_UCODE) hit = cond_i.ucode_start;
					else supported = 1'b0;
				end
				default: supported = 1'b0;
			endcase
		end
	end

	// Counter next value
	always_comb begin
		count_d = count_q;
		if (hit) begin
			count_d = count_q + CNT_W'(1);
		end
	end

	// Counter register
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			count_q <= CNT_RST;
		end else begin
			count_q <= count_d;
		end
	end

	assign count_o = count_q;
	assign supported_o = supported;
	assign hit_o = hit;

	// Selection matches for the checks, decoded apart from the counting path
	logic fam1;
	logic m_reorder_full;
	logic m_alloc_stall;
	logic m_no_alloc_all;
	logic m_undeliv;
	logic m_memq;
	logic m_any_station;
	logic m_div;
	logic m_resteer_any;
	logic m_resteer_ret;
	logic m_resteer_cond;
	logic m_ucode;
	logic m_st_fwd;
	logic m_seg_ld;
	logic any_match;
	logic [2:0] quiet_q;
	logic [2:0] quiet_d;

	// One flag per supported pair; a family never matches a pair of the other family
	always_comb begin
		fam1 = ~family2_i;
		m_reorder_full = fam1 & (sel_i.code == EV_NO_ALLOC) & (sel_i.umask == UM_REORDER_FULL);
		m_alloc_stall = fam1 & (sel_i.code == EV_NO_ALLOC) & (sel_i.umask == UM_ALLOC_STALL);
		m_no_alloc_all = fam1 & (sel_i.code == EV_NO_ALLOC) & (sel_i.umask == UM_NO_ALLOC_ALL);
		m_undeliv = fam1 & (sel_i.code == EV_NO_ALLOC) & (sel_i.umask == UM_UNDELIVERED);
		m_memq = fam1 & (sel_i.code == EV_STATION_FULL) & (sel_i.umask == UM_MEMQ);
		m_any_station = fam1 & (sel_i.code == EV_STATION_FULL) & (sel_i.umask == UM_ANY_STATION);
		m_div = fam1 & (sel_i.code == EV_DIV_BUSY) & (sel_i.umask == UM_DIV);
		m_resteer_any = fam1 & (sel_i.code == EV_RESTEER) & (sel_i.umask == UM_RST_ANY);
		m_resteer_ret = fam1 & (sel_i.code == EV_RESTEER) & (sel_i.umask == UM_RST_RET);
		m_resteer_cond = fam1 & (sel_i.code == EV_RESTEER) & (sel_i.umask == UM_RST_COND);
		m_ucode = fam1 & (sel_i.code == EV_UCODE) & (sel_i.umask == UM_UCODE);
		m_st_fwd = family2_i & (sel_i.code == EV_ST_FWD) & (sel_i.umask == UM_ST_FWD);
		m_seg_ld = family2_i & (sel_i.code == EV_SEG_LD); // Any unit mask
		any_match = m_reorder_full | m_alloc_stall | m_no_alloc_all | m_undeliv | m_memq;
		any_match = any_match | m_any_station | m_div | m_resteer_any | m_resteer_ret;
		any_match = any_match | m_resteer_cond | m_ucode | m_st_fwd | m_seg_ld;
	end

	// Length of the current run without a hit, saturating at all ones
	always_comb begin
		quiet_d = quiet_q;
		if (hit) begin
			quiet_d = 3'h0;
		end else if (~&quiet_q) begin
			quiet_d = quiet_q + 3'h1;
		end
	end

	// Quiet run register, cleared together with the counter
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			quiet_q <= 3'h0;
		end else begin
			quiet_q <= quiet_d;
		end
	end

	// Checks on the counter itself
	a_count_step: assert property (@(posedge clock_i) disable iff (rst_i)
		hit
		|=> count_q == $past(count_q) + CNT_W'(1))
		else $error("counter did not step by one");
	a_count_hold: assert property (@(posedge clock_i) disable iff (rst_i)
		!hit
		|=> $stable(count_q))
		else $error("counter moved without a hit");
	a_count_burst: assert property (@(posedge clock_i) disable iff (rst_i)
		hit [*4]
		|=> count_q == $past(count_q, 4) + CNT_W'(4))
		else $error("back to back hits not all counted");
	a_quiet_hold: assert property (@(posedge clock_i) disable iff (rst_i)
		&quiet_q
		|-> count_q == $past(count_q, 7))
		else $error("counter drifted over a run without hits");
	a_reset_clear: assert property (@(posedge clock_i)
		rst_i
		|=> count_q == CNT_RST)
		else $error("reset did not clear the counter");

	// Checks on refused selections
	a_unsup_hold: assert property (@(posedge clock_i) disable iff (rst_i)
		!supported
		|-> !hit)
		else $error("unsupported selection produced a hit");
	a_known_pair: assert property (@(posedge clock_i) disable iff (rst_i)
		any_match
		|-> supported)
		else $error("supported pair flagged as refused");
	a_unknown_pair: assert property (@(posedge clock_i) disable iff (rst_i)
		!any_match
		|-> !supported)
		else $error("refused pair flagged as supported");

	// Checks on the allocation events
	a_stall_alloc: assert property (@(posedge clock_i) disable iff (rst_i)
		m_alloc_stall
		|-> hit == (!cond_i.uops_allocated && cond_i.alloc_stall))
		else $error("allocation stall event wrong");
	a_frontend_all: assert property (@(posedge clock_i) disable iff (rst_i)
		m_no_alloc_all
		|-> hit == cond_i.frontend_empty)
		else $error("front end empty event wrong");
	a_undeliv_gate: assert property (@(posedge clock_i) disable iff (rst_i)
		m_undeliv && cond_i.backend_stalled
		|-> !hit)
		else $error("undelivered counted while back end stalled");
	a_undeliv_count: assert property (@(posedge clock_i) disable iff (rst_i)
		m_undeliv && !cond_i.backend_stalled
		|-> hit == cond_i.frontend_empty)
		else $error("undelivered event wrong while back end free");
	a_reorder_full: assert property (@(posedge clock_i) disable iff (rst_i)
		m_reorder_full
		|-> hit == (!cond_i.uops_allocated && cond_i.reorder_free < REORDER_FREE_W'(REORDER_FULL_LIMIT)))
		else $error("reorder full event wrong");
	a_reorder_alloc: assert property (@(posedge clock_i) disable iff (rst_i)
		m_reorder_full && cond_i.uops_allocated
		|-> !hit)
		else $error("reorder full counted while allocating");

	// Checks on the station full events
	a_station_only: assert property (@(posedge clock_i) disable iff (rst_i)
		m_any_station
		|-> hit == (cond_i.alloc_stall && cond_i.station_full != '0))
		else $error("any station stall wrong");
	a_station_other: assert property (@(posedge clock_i) disable iff (rst_i)
		m_any_station && cond_i.station_full == '0
		|-> !hit)
		else $error("stall without a full station counted");
	a_memq_stall: assert property (@(posedge clock_i) disable iff (rst_i)
		m_memq
		|-> hit == (cond_i.alloc_stall && cond_i.station_full[MEMQ_IDX]))
		else $error("memory station stall wrong");
	a_memq_clear: assert property (@(posedge clock_i) disable iff (rst_i)
		m_memq && !cond_i.station_full[MEMQ_IDX]
		|-> !hit)
		else $error("memory station stall counted while not full");

	// Checks on the divider event
	a_div_busy: assert property (@(posedge clock_i) disable iff (rst_i)
		m_div && cond_i.div_busy
		|=> count_q == $past(count_q) + CNT_W'(1))
		else $error("divider busy not counted");
	a_div_idle: assert property (@(posedge clock_i) disable iff (rst_i)
		m_div && !cond_i.div_busy
		|-> !hit)
		else $error("idle divider counted");

	// Checks on resteer and microcode events
	a_resteer_any: assert property (@(posedge clock_i) disable iff (rst_i)
		m_resteer_any
		|-> hit == cond_i.resteer)
		else $error("any resteer event wrong");
	a_resteer_ret: assert property (@(posedge clock_i) disable iff (rst_i)
		m_resteer_ret
		|-> hit == cond_i.resteer_ret)
		else $error("return resteer event wrong");
	a_resteer_cond: assert property (@(posedge clock_i) disable iff (rst_i)
		m_resteer_cond
		|-> hit == cond_i.resteer_cond)
		else $error("conditional resteer event wrong");
	a_ucode_start: assert property (@(posedge clock_i) disable iff (rst_i)
		m_ucode
		|-> hit == cond_i.ucode_start)
		else $error("microcode start event wrong");

	// Checks on the second family events
	a_store_fwd: assert property (@(posedge clock_i) disable iff (rst_i)
		m_st_fwd
		|-> hit == cond_i.st_fwd)
		else $error("store forward event wrong");
	a_seg_load: assert property (@(posedge clock_i) disable iff (rst_i)
		m_seg_ld
		|-> hit == cond_i.seg_load)
		else $error("segment load event wrong");
	a_seg_count: assert property (@(posedge clock_i) disable iff (rst_i)
		m_seg_ld && cond_i.seg_load
		|=> count_q == $past(count_q) + CNT_W'(1))
		else $error("segment load not counted");

endmodule : pesc_counter

// ### include/pesc_pkg.sv
// Package for the pipeline event select counter: encodings, widths and condition carrier
package pesc_pkg;
	localparam int unsigned CODE_W = 8;
	localparam int unsigned CNT_W = 48;
	localparam int unsigned NUM_STATIONS = 6;
	localparam int unsigned REORDER_FULL_LIMIT = 2;
	localparam int unsigned REORDER_FREE_W = 6;
	// Event codes
	localparam logic [7:0] EV_NO_ALLOC = 8'hCA;
	localparam logic [7:0] EV_STATION_FULL = 8'hCB;
	localparam logic [7:0] EV_DIV_BUSY = 8'hCD;
	localparam logic [7:0] EV_RESTEER = 8'hE6;
	localparam logic [7:0] EV_UCODE = 8'hE7;
	localparam logic [7:0] EV_ST_FWD = 8'h02;
	localparam logic [7:0] EV_SEG_LD = 8'h06;
	// Unit masks
	localparam logic [7:0] UM_REORDER_FULL = 8'h01;
	localparam logic [7:0] UM_ALLOC_STALL = 8'h20;
	localparam logic [7:0] UM_NO_ALLOC_ALL = 8'h3F;
	localparam logic [7:0] UM_UNDELIVERED = 8'h50;
	localparam logic [7:0] UM_MEMQ = 8'h01;
	localparam logic [7:0] UM_ANY_STATION = 8'h1F;
	localparam logic [7:0] UM_DIV = 8'h01;
	localparam logic [7:0] UM_RST_ANY = 8'h01;
	localparam logic [7:0] UM_RST_RET = 8'h08;
	localparam logic [7:0] UM_RST_COND = 8'h10;
	localparam logic [7:0] UM_UCODE = 8'h01;
	localparam logic [7:0] UM_ST_FWD = 8'h81;
	localparam logic [7:0] UM_SEG_LD = 8'h00;
	// Index of the memory execution cluster station
	localparam int unsigned MEMQ_IDX = 0;
	localparam logic [CNT_W-1:0] CNT_RST = '0;

	// Condition signals from the pipeline, all valid for the current cycle
	typedef struct packed {
		logic uops_allocated;
		logic alloc_stall;
		logic [REORDER_FREE_W-1:0] reorder_free;
		logic frontend_empty;
		logic backend_stalled;
		logic [NUM_STATIONS-1:0] station_full;
		logic div_busy;
		logic resteer;
		logic resteer_ret;
		logic resteer_cond;
		logic ucode_start;
		logic st_fwd;
		logic seg_load;
	} pesc_cond_t;

	// Programmed event selection
	typedef struct packed {
		logic [CODE_W-1:0] code;
		logic [CODE_W-1:0] umask;
	} pesc_sel_t;
endpackage : pesc_pkg

// ### verification/pesc_counter_tb.sv
// Self-checking bench for the event select counter
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; $display("Error %0t: got %0h expected %0h", $time, (a), (b)); end end
module pesc_counter_tb;
	import pesc_pkg::*;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	pesc_sel_t sel = '0;
	logic fam = 1'b0;
	logic [31:0] rnd = 32'h29;
	pesc_cond_t cond;
	logic [CNT_W-1:0] count;
	logic sup;
	logic hit;
	logic [1:0] m;
	int n_mismatch = 0;
	int n_tests = 0;
	longint exp_cnt = 0;
	// Family bit, code and mask; last five are refused pairs
	logic [16:0] sels [18] = '{17'h0CA20, 17'h0CA3F, 17'h0CA50, 17'h0CA01, 17'h0CB01, 17'h0CB1F, 17'h0CD01,
		17'h0E601, 17'h0E608, 17'h0E610, 17'h0E701, 17'h10281, 17'h10600,
		17'h0CA02, 17'h00281, 17'h1CB1F, 17'h0E602, 17'h0CD00};
	always #20 clock_i = ~clock_i;
	pesc_pipe_model i_pipe (.rnd_i(rnd), .cond_o(cond));
	pesc_counter i_dut (.clock_i(clock_i), .rst_i(rst_i), .sel_i(sel), .family2_i(fam), .cond_i(cond),
		.count_o(count), .supported_o(sup), .hit_o(hit));
	// Next random word
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Reference: {supported, qualifies}
	function automatic logic [1:0] model(input pesc_sel_t s, input logic f, input pesc_cond_t c);
		if (f) begin
			if (s.code == 8'h02 && s.umask == 8'h81) return {1'b1, c.st_fwd};
			if (s.code == 8'h06) return {1'b1, c.seg_load};
			return 2'b00;
		end
		case ({s.code, s.umask})
			16'hCA20: return {1'b1, !c.uops_allocated && c.alloc_stall};
			16'hCA3F: return {1'b1, c.frontend_empty};
			16'hCA50: return {1'b1, c.frontend_empty && !c.backend_stalled};
			16'hCA01: return {1'b1, !c.uops_allocated && c.reorder_free < 2};
			16'hCB01: return {1'b1, c.alloc_stall && c.station_full[0]};
			16'hCB1F: return {1'b1, c.alloc_stall && (|c.station_full)};
			16'hCD01: return {1'b1, c.div_busy};
			16'hE601: return {1'b1, c.resteer};
			16'hE608: return {1'b1, c.resteer_ret};
			16'hE610: return {1'b1, c.resteer_cond};
			16'hE701: return {1'b1, c.ucode_start};
			default: return 2'b00;
		endcase
	endfunction : model
	// Verdict and end of run
	task final_report;
		if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : final_report
	// Watchdog
	initial begin
		#(40 * 2000);
		n_mismatch++;
		final_report();
	end
	// Main sequence: every selection, random conditions each cycle
	initial begin
		repeat (3) @(posedge clock_i);
		@(negedge clock_i) rst_i = 1'b0;
		for (int i = 0; i < 18; i++) begin
			for (int k = 0; k < 40; k++) begin
				@(negedge clock_i);
				`CHK(count, exp_cnt[CNT_W-1:0])
				rnd = lfsr(rnd);
				{fam, sel} = (sels[i][16] && sels[i][15:8] == 8'h06) ? {sels[i][16:8], rnd[15:8]} : sels[i];
				#1;
				m = model(sel, fam, cond);
				`CHK(sup, m[1])
				`CHK(hit, m[0])
				if (m[0]) exp_cnt++;
			end
		end
		// Last count of the sweep, then a reset in mid-run clears it
		@(negedge clock_i);
		`CHK(count, exp_cnt[CNT_W-1:0])
		rst_i = 1'b1;
		@(negedge clock_i);
		`CHK(count, CNT_RST)
		rst_i = 1'b0;
		exp_cnt = 0;
		// Counting restarts from zero on the divider event
		for (int k = 0; k < 40; k++) begin
			@(negedge clock_i);
			`CHK(count, exp_cnt[CNT_W-1:0])
			rnd = lfsr(rnd);
			{fam, sel} = sels[6];
			#1;
			m = model(sel, fam, cond);
			`CHK(sup, m[1])
			`CHK(hit, m[0])
			if (m[0]) exp_cnt++;
		end
		@(negedge clock_i);
		`CHK(count, exp_cnt[CNT_W-1:0])
		final_report();
	end
endmodule : pesc_counter_tb

// ### verification/pesc_pipe_model.sv
// Pipeline model that turns a random word into one cycle of condition signals
`timescale 1ns/100ps
module pesc_pipe_model
	import pesc_pkg::*;
(
	// Random source
	input wire logic [31:0] rnd_i,
	// Conditions
	output pesc_cond_t cond_o
);
	// Allocation stalls on a full station, or now and then for other causes
	always_comb begin
		cond_o.station_full = rnd_i[13] ? 6'h00 : rnd_i[19:14];
		cond_o.alloc_stall = rnd_i[1] | (|cond_o.station_full);
		cond_o.uops_allocated = rnd_i[0] & ~cond_o.alloc_stall;
		cond_o.reorder_free = rnd_i[2] ? {4'h0, rnd_i[4:3]} : rnd_i[10:5]; // Often near full
		cond_o.frontend_empty = rnd_i[11];
		cond_o.backend_stalled = rnd_i[12];
		cond_o.div_busy = rnd_i[20];
		cond_o.resteer = rnd_i[21];
		cond_o.resteer_ret = rnd_i[21] & rnd_i[22];
		cond_o.resteer_cond = rnd_i[21] & rnd_i[23] & ~rnd_i[22];
		cond_o.ucode_start = rnd_i[24];
		cond_o.st_fwd = rnd_i[25];
		cond_o.seg_load = rnd_i[26]; // Speculative loads look the same
	end
endmodule : pesc_pipe_model
